// ==== shared/lbce_pkg.sv ====
// Constants and types shared by the loop, branch and call execution block
package lbce_pkg;
	localparam logic [7:0] OPC_LOOP = 8'h10;
	localparam logic [7:0] OPC_CALL = 8'hcd;
	localparam logic [1:0] CCALL_HEAD = 2'h3;
	localparam logic [2:0] CCALL_TAIL = 3'h4;
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_ZERO = 6;
	localparam int FLAG_SIGN = 7;
	localparam logic [1:0] CSEL_ZERO = 2'h0;
	localparam logic [1:0] CSEL_CARRY = 2'h1;
	localparam logic [1:0] CSEL_PARITY = 2'h2;
	localparam logic [1:0] CSEL_SIGN = 2'h3;
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC = 8'h08;
	localparam logic [7:0] REG_SP = 8'h0c;
	localparam logic [7:0] REG_COUNT = 8'h10;
	localparam logic [7:0] REG_FLAGS = 8'h14;
	localparam int CTRL_START = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ILLEGAL = 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [2:0] T_FETCH = 3'h4;
	localparam logic [2:0] T_FETCH_LOOP = 3'h5;
	localparam logic [2:0] T_OPCODE_SAMPLE = 3'h2;
	localparam logic [2:0] T_MEM = 3'h3;
	localparam logic [2:0] T_OPHI_PUSH = 3'h4;
	localparam logic [2:0] T_BRANCH = 3'h5;
	localparam logic [4:0] CYC_LOOP_TAKEN = 5'h0d;
	localparam logic [4:0] CYC_LOOP_DONE = 5'h08;
	localparam logic [4:0] CYC_CALL = 5'h11;
	localparam logic [4:0] CYC_CALL_SKIP = 5'h0a;
	localparam logic [15:0] PC_STEP_REL = 16'h0002;
	localparam logic [15:0] PC_STEP_CALL = 16'h0003;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FETCH = 3'b001,
		S_DISP = 3'b010,
		S_BRANCH = 3'b011,
		S_OPLO = 3'b100,
		S_OPHI = 3'b101,
		S_PUSHH = 3'b110,
		S_PUSHL = 3'b111
	} lbce_state_type;
endpackage : lbce_pkg

// ==== verilog/lbce_cond_eval.sv ====
// Condition field evaluation against the flag byte
`timescale 1ns/1ps
`default_nettype none
module lbce_cond_eval
	import lbce_pkg::*;
(
	input wire logic [7:0] flags,
	input wire logic [2:0] condition_select_field,
	output logic cond_hold
);
	logic flag_bit;
	always_comb begin
		case (condition_select_field[2:1])
			CSEL_ZERO: flag_bit = flags[FLAG_ZERO];
			CSEL_CARRY: flag_bit = flags[FLAG_CARRY];
			CSEL_PARITY: flag_bit = flags[FLAG_PARITY];
			CSEL_SIGN: flag_bit = flags[FLAG_SIGN];
			default: flag_bit = 1'b0;
		endcase
		// Even codes hold on a clear flag, odd codes on a set one
		cond_hold = (flag_bit == condition_select_field[0]);
	end
endmodule : lbce_cond_eval
`default_nettype wire

// ==== verilog/lbce_ahb_slave.sv ====
// AHB-Lite slave: write strobes and registered read data with one wait state
`timescale 1ns/1ps
`default_nettype none
module lbce_ahb_slave
	import lbce_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wr_en,
	output logic [ADDR_W-1:0] reg_index,
	output logic [31:0] wr_data,
	input wire logic [31:0] rd_value
);
	logic wr_pend, rd_pend, accept;
	logic next_wr_pend, next_rd_pend, next_hreadyout;
	logic [ADDR_W-1:0] next_reg_index;
	logic [31:0] next_hrdata;
	assign accept = hsel && htrans[1] && hready && (hsize == HSIZE_WORD);
	assign wr_en = wr_pend;
	assign wr_data = hwdata;
	always_comb begin
		next_wr_pend = accept && hwrite;
		next_rd_pend = accept && !hwrite;
		next_reg_index = accept ? haddr[ADDR_W-1:0] : reg_index;
		// Reads stall one cycle so that the data leave a flop
		next_hreadyout = !(accept && !hwrite);
		next_hrdata = rd_pend ? rd_value : hrdata;
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			reg_index <= '0;
			hreadyout <= 1'b1;
			hrdata <= 32'h0000_0000;
			hresp <= 1'b0;
		end else if (clk_en) begin
			wr_pend <= next_wr_pend;
			rd_pend <= next_rd_pend;
			reg_index <= next_reg_index;
			hreadyout <= next_hreadyout;
			hrdata <= next_hrdata;
			hresp <= 1'b0;
		end
	end
endmodule : lbce_ahb_slave
`default_nettype wire

// ==== verilog/lbce_exec.sv ====
// Execution of the decrement-and-branch, call and conditional call instructions
//
// Summary of operation
// - Opcode 10h decrements loop counter; nonzero result branches relative to PC.
// - Displacement is two's complement from opcode address, reach -126 to +129.
// - Zero count after decrement: no branch, continue after the two-byte instruction.
// - Loop takes 13 states (5,3,5) when taken, 8 states (5,3) otherwise.
// - Call is CDh, then target low byte, then target high byte.
// - Push: decrement SP, write PC high; decrement SP, write PC low.
// - Pushed return address is call opcode address plus three.
// - After the push the target is loaded into PC.
// - Conditional call pushes and jumps only when its condition holds.
// - Condition field selects zero, carry, parity or sign, clear or set.
// - Untaken conditional call still reads both operands, 10 states (4,3,3).
`timescale 1ns/1ps
`default_nettype none
module lbce_exec
	import lbce_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic mem_rd,
	output logic mem_wr
);
	lbce_state_type state, next_state;
	logic [2:0] tcnt, next_tcnt, tlen;
	logic [15:0] pc, next_pc, sp, next_sp, tgt, next_tgt, op_addr, next_op_addr;
	logic [15:0] next_mem_addr, pc_inc, disp_ext;
	logic [7:0] count, next_count, flags, next_flags, opcode, next_opcode, disp, next_disp;
	logic [7:0] next_mem_wdata;
	logic done, next_done, illegal, next_illegal, next_mem_rd, next_mem_wr;
	logic [4:0] run_len, next_run_len;
	logic wr_en, cond_hold, is_ccall, take_call, last_t, idle;
	logic [ADDR_W-1:0] reg_index;
	logic [31:0] wr_data, rd_value;

	lbce_ahb_slave u_slave (
		.mclk(mclk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.reg_index(reg_index),
		.wr_data(wr_data),
		.rd_value(rd_value)
	);

	lbce_cond_eval u_cond (
		.flags(flags),
		.condition_select_field(opcode[5:3]),
		.cond_hold(cond_hold)
	);

	assign idle = (state == S_IDLE);
	assign is_ccall = (opcode[7:6] == CCALL_HEAD) && (opcode[2:0] == CCALL_TAIL);
	assign take_call = (opcode == OPC_CALL) || (is_ccall && cond_hold);
	assign pc_inc = pc + 16'h0001;
	assign disp_ext = {{8{disp[7]}}, disp};
	assign last_t = (tcnt == tlen - 3'h1);

	always_comb begin
		case (state)
			S_FETCH: tlen = (opcode == OPC_LOOP) ? T_FETCH_LOOP : T_FETCH;
			S_OPHI: tlen = take_call ? T_OPHI_PUSH : T_MEM;
			S_BRANCH: tlen = T_BRANCH;
			default: tlen = T_MEM;
		endcase
	end

	always_comb begin
		case (reg_index)
			REG_STATUS: rd_value = {29'h0000_0000, illegal, done, !idle};
			REG_PC: rd_value = {16'h0000, pc};
			REG_SP: rd_value = {16'h0000, sp};
			REG_COUNT: rd_value = {24'h00_0000, count};
			REG_FLAGS: rd_value = {24'h00_0000, flags};
			default: rd_value = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_state = state;
		next_tcnt = tcnt;
		next_pc = pc;
		next_sp = sp;
		next_tgt = tgt;
		next_op_addr = op_addr;
		next_count = count;
		next_flags = flags;
		next_opcode = opcode;
		next_disp = disp;
		next_done = done;
		next_illegal = illegal;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_rd = mem_rd;
		next_mem_wr = mem_wr;
		next_run_len = idle ? 5'h00 : run_len + 5'h01;
		// Software writes land only while the sequencer rests
		if (idle && wr_en) begin
			case (reg_index)
				REG_PC: next_pc = wr_data[15:0];
				REG_SP: next_sp = wr_data[15:0];
				REG_COUNT: next_count = wr_data[7:0];
				REG_FLAGS: next_flags = wr_data[7:0];
				REG_CTRL: begin
					if (wr_data[CTRL_START]) begin
						next_state = S_FETCH;
						next_tcnt = 3'h0;
						next_op_addr = pc;
						next_opcode = 8'h00;
						next_done = 1'b0;
						next_illegal = 1'b0;
						next_mem_addr = pc;
						next_mem_rd = 1'b1;
					end
				end
				default: next_state = state;
			endcase
		end else if (!idle) begin
			next_tcnt = last_t ? 3'h0 : tcnt + 3'h1;
			if (state == S_FETCH && tcnt == T_OPCODE_SAMPLE) begin
				next_opcode = mem_rdata;
			end
			if (last_t) begin
				next_mem_rd = 1'b0;
				next_mem_wr = 1'b0;
				case (state)
					S_FETCH: begin
						next_pc = pc_inc;
						next_mem_addr = pc_inc;
						if (opcode == OPC_LOOP) begin
							next_count = count - 8'h01;
							next_state = S_DISP;
							next_mem_rd = 1'b1;
						end else if (opcode == OPC_CALL || is_ccall) begin
							next_state = S_OPLO;
							next_mem_rd = 1'b1;
						end else begin
							next_state = S_IDLE;
							next_done = 1'b1;
							next_illegal = 1'b1;
						end
					end
					S_DISP: begin
						next_disp = mem_rdata;
						next_pc = pc_inc;
						if (count != 8'h00) begin
							next_state = S_BRANCH;
						end else begin
							next_state = S_IDLE;
							next_done = 1'b1;
						end
					end
					S_BRANCH: begin
						next_pc = pc + disp_ext;
						next_state = S_IDLE;
						next_done = 1'b1;
					end
					S_OPLO: begin
						next_tgt = {tgt[15:8], mem_rdata};
						next_pc = pc_inc;
						next_mem_addr = pc_inc;
						next_mem_rd = 1'b1;
						next_state = S_OPHI;
					end
					S_OPHI: begin
						next_tgt = {mem_rdata, tgt[7:0]};
						next_pc = pc_inc;
						if (take_call) begin
							next_sp = sp - 16'h0001;
							next_mem_addr = sp - 16'h0001;
							next_mem_wdata = pc_inc[15:8];
							next_mem_wr = 1'b1;
							next_state = S_PUSHH;
						end else begin
							next_state = S_IDLE;
							next_done = 1'b1;
						end
					end
					S_PUSHH: begin
						next_sp = sp - 16'h0001;
						next_mem_addr = sp - 16'h0001;
						next_mem_wdata = pc[7:0];
						next_mem_wr = 1'b1;
						next_state = S_PUSHL;
					end
					S_PUSHL: begin
						next_pc = tgt;
						next_state = S_IDLE;
						next_done = 1'b1;
					end
					default: next_state = S_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= S_IDLE;
			tcnt <= 3'h0;
			pc <= 16'h0000;
			sp <= 16'h0000;
			tgt <= 16'h0000;
			op_addr <= 16'h0000;
			count <= 8'h00;
			flags <= 8'h00;
			opcode <= 8'h00;
			disp <= 8'h00;
			done <= 1'b0;
			illegal <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			run_len <= 5'h00;
		end else if (clk_en) begin
			state <= next_state;
			tcnt <= next_tcnt;
			pc <= next_pc;
			sp <= next_sp;
			tgt <= next_tgt;
			op_addr <= next_op_addr;
			count <= next_count;
			flags <= next_flags;
			opcode <= next_opcode;
			disp <= next_disp;
			done <= next_done;
			illegal <= next_illegal;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			mem_rd <= next_mem_rd;
			mem_wr <= next_mem_wr;
			run_len <= next_run_len;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence s_end(lbce_state_type st);
		clk_en && state == st && last_t;
	endsequence

	property p_loop_taken_len;
		s_end(S_BRANCH) |-> run_len == CYC_LOOP_TAKEN - 5'h01;
	endproperty
	a_loop_taken_len: assert property (p_loop_taken_len) else $error("loop taken length wrong");

	property p_loop_done_len;
		s_end(S_DISP) ##0 (count == 8'h00) |-> run_len == CYC_LOOP_DONE - 5'h01;
	endproperty
	a_loop_done_len: assert property (p_loop_done_len) else $error("loop exit length wrong");

	property p_call_len;
		s_end(S_PUSHL) |-> run_len == CYC_CALL - 5'h01;
	endproperty
	a_call_len: assert property (p_call_len) else $error("call length wrong");

	property p_skip_len;
		s_end(S_OPHI) ##0 !take_call |-> run_len == CYC_CALL_SKIP - 5'h01 ##1 pc == op_addr + PC_STEP_CALL;
	endproperty
	a_skip_len: assert property (p_skip_len) else $error("skipped call length or pc wrong");

	property p_branch_target;
		s_end(S_BRANCH) |=> pc == op_addr + PC_STEP_REL + disp_ext && state == S_IDLE;
	endproperty
	a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

	property p_loop_exit_pc;
		s_end(S_DISP) ##0 (count == 8'h00) |=> pc == op_addr + PC_STEP_REL && state == S_IDLE;
	endproperty
	a_loop_exit_pc: assert property (p_loop_exit_pc) else $error("loop exit pc wrong");

	property p_push_high;
		clk_en && state == S_PUSHH |-> mem_wr && mem_addr == sp && mem_wdata == pc[15:8] && pc == op_addr + PC_STEP_CALL;
	endproperty
	a_push_high: assert property (p_push_high) else $error("return high byte push wrong");

	property p_push_order;
		s_end(S_PUSHH) |=> state == S_PUSHL && mem_addr == $past(sp) - 16'h0001 && mem_wdata == pc[7:0];
	endproperty
	a_push_order: assert property (p_push_order) else $error("return low byte push wrong");

	property p_jump_target;
		s_end(S_PUSHL) |=> pc == tgt && !mem_wr;
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("call target not loaded");

	property p_flags_kept;
		!idle |=> $stable(flags);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flags changed during execution");
endmodule : lbce_exec
`default_nettype wire

// ==== verification/lbce_mem_model.sv ====
// Byte-wide program and stack memory on the far side of the execution block
`timescale 1ns/1ps
`default_nettype none
module lbce_mem_model (
	input wire logic mclk,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	input wire logic mem_rd,
	input wire logic mem_wr
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	// Released data line shows the inverse of the last byte, never a stale copy
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
	always @(posedge mclk) begin
		if (mem_rd) begin
			last <= mem[mem_addr];
		end
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
	end
endmodule : lbce_mem_model
`default_nettype wire

// ==== verification/loop_branch_and_call_exec_tb.sv ====
// Self-checking bench for the loop, branch and call execution block
`timescale 1ns/1ps
`default_nettype none
module loop_branch_and_call_exec_tb
	import lbce_pkg::*;
;
	typedef struct {bit c; logic [31:0] e; string n;} lbce_note_type;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic mem_rd;
	logic mem_wr;
	logic [31:0] lfsr = 32'h60b2_1ce8;
	int err_total = 0;
	int cmp_count = 0;
	int rd_cnt = 0;
	int wr_cnt = 0;
	bit dp_rd = 1'b0;
	lbce_note_type note_q[$];
	logic [7:0] loop_cnt [3] = '{8'h02, 8'h01, 8'h00};
	logic [7:0] loop_disp [3] = '{8'h80, 8'h05, 8'h7f};
	logic [15:0] loop_pc [3] = '{16'h0382, 16'h0402, 16'h0481};
	int bit_sel [4] = '{FLAG_ZERO, FLAG_CARRY, FLAG_PARITY, FLAG_SIGN};
	always #12.5 mclk = ~mclk;
	lbce_exec dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
		.hrdata(hrdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
		.mem_wr(mem_wr));
	lbce_mem_model mem_u (.mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_rd(mem_rd), .mem_wr(mem_wr));
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr_next
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Read results are matched against the oldest note as each data phase ends
	always @(posedge mclk) begin
		lbce_note_type nt;
		if (mem_rd === 1'b1) rd_cnt++;
		if (mem_wr === 1'b1) wr_cnt++;
		if (dp_rd && hready === 1'b1) begin
			nt = note_q.pop_front();
			chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
			if (nt.c) chk(nt.n, nt.e, hrdata);
		end
		if (hready === 1'b1) dp_rd = htrans[1] && !hwrite;
	end
	task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h00_0000, a};
		hwrite <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
	endtask : ahb_wr
	task automatic ahb_rd(input logic [7:0] a, input bit c, input logic [31:0] e, input string n,
		output logic [31:0] d);
		note_q.push_back('{c, e, n});
		haddr <= {24'h00_0000, a};
		hwrite <= 1'b0;
		htrans <= HTRANS_NONSEQ;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		do @(posedge mclk); while (hready !== 1'b1);
		d = hrdata;
	endtask : ahb_rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
		logic [31:0] d;
		ahb_rd(a, 1'b1, e, n, d);
	endtask : rdc
	task automatic run(input logic [15:0] pc, input logic [15:0] sp, input logic [7:0] cnt, input logic [7:0] fl);
		logic [31:0] st;
		int n;
		ahb_wr(REG_PC, {16'h0000, pc});
		ahb_wr(REG_SP, {16'h0000, sp});
		ahb_wr(REG_COUNT, {24'h00_0000, cnt});
		ahb_wr(REG_FLAGS, {24'h00_0000, fl});
		rd_cnt = 0;
		wr_cnt = 0;
		ahb_wr(REG_CTRL, 32'h0000_0001);
		n = 0;
		st = 32'h0000_0000;
		while (st[ST_DONE] !== 1'b1 && n < 50) begin
			ahb_rd(REG_STATUS, 1'b0, 32'h0000_0000, "status", st);
			n++;
		end
		// A poll limit that runs out counts as a mismatch
		chk("done", 32'h0000_0001, {31'h0000_0000, st[ST_DONE]});
	endtask : run
	task automatic expect_state(input logic [15:0] pc, input logic [15:0] sp, input logic [7:0] cnt,
		input logic [7:0] fl, input int nrd, input int nwr);
		rdc(REG_PC, {16'h0000, pc}, "pc");
		rdc(REG_SP, {16'h0000, sp}, "sp");
		rdc(REG_COUNT, {24'h00_0000, cnt}, "count");
		rdc(REG_FLAGS, {24'h00_0000, fl}, "flags");
		chk("read_cycles", 32'(nrd), 32'(rd_cnt));
		chk("write_cycles", 32'(nwr), 32'(wr_cnt));
	endtask : expect_state
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		#500000;
		err_total++;
		finish_test();
	end
	initial begin
		logic [15:0] op;
		logic [15:0] tgt;
		logic [15:0] ret;
		logic [7:0] fl;
		logic [2:0] cc;
		logic hold;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rdc(REG_STATUS, 32'h0000_0000, "status");
		rdc(REG_CTRL, 32'h0000_0000, "ctrl");
		ahb_wr(8'h40, 32'hffff_ffff);
		rdc(8'h40, 32'h0000_0000, "unmapped");
		expect_state(16'h0000, 16'h0000, 8'h00, 8'h00, 0, 0);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			mem_u.mem[16'h0400] = OPC_LOOP;
			mem_u.mem[16'h0401] = loop_disp[i];
			fl = lfsr[7:0];
			lfsr = lfsr_next(lfsr);
			run(16'h0400, 16'h9000, loop_cnt[i], fl);
			expect_state(loop_pc[i], 16'h9000, loop_cnt[i] - 8'h01, fl, 8, 0);
		end
		$display("test loop done");
		tgt = lfsr[15:0];
		lfsr = lfsr_next(lfsr);
		mem_u.mem[16'h1a47] = OPC_CALL;
		mem_u.mem[16'h1a48] = tgt[7:0];
		mem_u.mem[16'h1a49] = tgt[15:8];
		run(16'h1a47, 16'h3002, 8'h00, fl);
		expect_state(tgt, 16'h3000, 8'h00, fl, 11, 6);
		chk("stack_high", 32'h0000_001a, {24'h00_0000, mem_u.mem[16'h3001]});
		chk("stack_low", 32'h0000_004a, {24'h00_0000, mem_u.mem[16'h3000]});
		$display("test call done");
		for (int k = 0; k < 16; k++) begin
			cc = k[3:1];
			op = 16'h2000 + 16'(k * 8);
			ret = op + 16'h0003;
			tgt = lfsr[15:0];
			lfsr = lfsr_next(lfsr);
			fl = lfsr[7:0];
			lfsr = lfsr_next(lfsr);
			fl[bit_sel[cc[2:1]]] = k[0];
			hold = (cc[0] == k[0]);
			mem_u.mem[op] = {CCALL_HEAD, cc, CCALL_TAIL};
			mem_u.mem[op + 16'h0001] = tgt[7:0];
			mem_u.mem[op + 16'h0002] = tgt[15:8];
			mem_u.mem[16'h7fff] = 8'hee;
			mem_u.mem[16'h7ffe] = 8'hee;
			run(op, 16'h8000, 8'h00, fl);
			expect_state(hold ? tgt : ret, hold ? 16'h7ffe : 16'h8000, 8'h00, fl, hold ? 11 : 10,
				hold ? 6 : 0);
			chk("stack_high", {24'h00_0000, hold ? ret[15:8] : 8'hee}, {24'h00_0000, mem_u.mem[16'h7fff]});
			chk("stack_low", {24'h00_0000, hold ? ret[7:0] : 8'hee}, {24'h00_0000, mem_u.mem[16'h7ffe]});
		end
		$display("test conditional call done");
		mem_u.mem[16'h0500] = 8'h00;
		run(16'h0500, 16'h9000, 8'h05, 8'h00);
		rdc(REG_STATUS, 32'h0000_0006, "status");
		expect_state(16'h0501, 16'h9000, 8'h05, 8'h00, 4, 0);
		$display("test illegal opcode done");
		finish_test();
	end
endmodule : loop_branch_and_call_exec_tb
`default_nettype wire
